/* File: rtl/ddr2_cmd_pkg.sv */
// constants, types and encodings shared by the ddr2 command-level core
// Contract
// - write with A10 high auto-precharges after recovery
// - write recovery setting accepts 2 to 6
// - other banks accept commands during auto-precharge
// - refresh decode uses internal row counter
// - refresh leaves banks idle; host waits tRFC
// - refresh with CKE low enters self-refresh
// - self-refresh ignores inputs but CKE; gates clock
// - CKE low with NOP enters power-down
// - power-down type by bank state, A12 exit
// - power-down disables buffers and most DLL
// - CKE high with NOP leaves power-down
package ddr2_cmd_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 8;
    localparam int BANK_W    = 3;
    localparam int ADDR_W    = 14;
    localparam int ROW_W     = 14;
    localparam int AP_BIT    = 10;
    localparam int DLY_W     = 5;

    // ------------------------------------------------------------
    // timing, in ns and derived cycles at 200 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_RAS_NS      = 45;
    localparam int T_RP_NS       = 15;
    localparam int T_RFC_NS      = 128;
    localparam int T_REFI_NS     = 7800;

    localparam logic [7:0]  T_RAS_CYC  = 8'((T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  T_RP_CYC   = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  T_RFC_CYC  = 8'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // internal self-refresh interval: longest time, rounds down
    localparam logic [11:0] T_REFI_CYC = 12'(T_REFI_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // mode limits and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] WR_MIN       = 3'h2;
    localparam logic [2:0] WR_MAX       = 3'h6;
    localparam logic [2:0] WR_RESET     = 3'h2;
    localparam logic [2:0] HALF_BL4     = 3'h2;
    localparam logic [2:0] HALF_BL8     = 3'h4;
    localparam logic [ROW_W-1:0] ROW_RESET = 14'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } cmd_bus_type;

    typedef struct packed {
        logic [2:0] cas_lat;
        logic [2:0] add_lat;
        logic       burst8;
        logic [2:0] wr_cycles;
        logic       slow_exit;
    } mode_type;

    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_SELF_REF = 2'b01,
        ST_PRE_PD   = 2'b10,
        ST_ACT_PD   = 2'b11
    } power_state_type;

endpackage : ddr2_cmd_pkg

/* File: rtl/ddr2_bank_state.sv */
// one bank: row open flag, tRAS tracking, auto-precharge and tRP timing
`timescale 1ns/100ps
module ddr2_bank_state (
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_reset_n,
    input  wire logic                            i_activate,
    input  wire logic                            i_precharge,
    input  wire logic                            i_auto_pre,
    input  wire logic [ddr2_cmd_pkg::DLY_W-1:0]  i_ap_delay,
    output logic                                 o_open,
    output logic                                 o_idle
);
    import ddr2_cmd_pkg::*;

    logic             open_q;
    logic [7:0]       ras_cnt_q;
    logic             ap_pend_q;
    logic [DLY_W-1:0] ap_cnt_q;
    logic [7:0]       rp_cnt_q;
    logic             ap_fire;
    logic             pre_start;

    // auto-precharge held back by the ras lockout until tRAS is met; explicit precharge is not
    assign ap_fire   = ap_pend_q && (ap_cnt_q == '0) && (ras_cnt_q >= T_RAS_CYC);
    assign pre_start = ap_fire || (i_precharge && open_q && !ap_pend_q);

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            open_q <= 1'b0;
        end else if (i_activate) begin
            open_q <= 1'b1;
        end else if (pre_start) begin
            open_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ras_cnt_q <= 8'h00;
        end else if (i_activate) begin
            ras_cnt_q <= 8'h01;
        end else if (ras_cnt_q != 8'hFF) begin
            ras_cnt_q <= ras_cnt_q + 8'h01;
        end
    end

    // write-AP delay counts the burst end plus programmed recovery
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ap_pend_q <= 1'b0;
            ap_cnt_q  <= '0;
        end else if (i_auto_pre && open_q) begin
            ap_pend_q <= 1'b1;
            // loaded one short so precharge lands on the edge the delay ends
            ap_cnt_q  <= i_ap_delay - DLY_W'(1);
        end else if (ap_fire) begin
            ap_pend_q <= 1'b0;
        end else if (ap_pend_q && ap_cnt_q != '0) begin
            ap_cnt_q <= ap_cnt_q - DLY_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rp_cnt_q <= 8'h00;
        end else if (pre_start) begin
            rp_cnt_q <= T_RP_CYC;
        end else if (rp_cnt_q != 8'h00) begin
            rp_cnt_q <= rp_cnt_q - 8'h01;
        end
    end

    assign o_open = open_q;
    assign o_idle = !open_q && !ap_pend_q && (rp_cnt_q == 8'h00);

endmodule : ddr2_bank_state

/* File: rtl/ddr2_cmd_core.sv */
// ddr2 command decode, bank tracking, refresh, self-refresh and power-down
`timescale 1ns/100ps
module ddr2_cmd_core (
    input  wire logic                               i_sys_clk,
    input  wire logic                               i_reset_n,
    input  wire ddr2_cmd_pkg::cmd_bus_type          i_cmd,
    input  wire ddr2_cmd_pkg::mode_type             i_mode,
    output ddr2_cmd_pkg::power_state_type           o_power_state,
    output logic [ddr2_cmd_pkg::NUM_BANKS-1:0]      o_bank_open,
    output logic                                    o_all_idle,
    output logic                                    o_refresh_busy,
    output logic                                    o_refresh_strobe,
    output logic [ddr2_cmd_pkg::ROW_W-1:0]          o_refresh_row,
    output logic                                    o_clk_gated,
    output logic                                    o_input_buf_en,
    output logic                                    o_dll_enable,
    output logic [2:0]                              o_wr_setting,
    output logic                                    o_wr_reject
);
    import ddr2_cmd_pkg::*;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic            cke_prev_q;
    power_state_type state_q;
    power_state_type state_d;
    logic            cmd_live;
    logic            is_nop;
    logic            is_act;
    logic            is_rw;
    logic            is_pre;
    logic            is_ref;
    logic            do_act;
    logic            do_rw;
    logic            do_pre;
    logic            do_ref;
    logic            enter_sr;
    logic            enter_pd;
    logic            leave_low;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= i_cmd.cke;
        end
    end

    assign is_nop = i_cmd.cs_n || (i_cmd.ras_n && i_cmd.cas_n && i_cmd.we_n);
    assign is_act = !i_cmd.cs_n && !i_cmd.ras_n && i_cmd.cas_n && i_cmd.we_n;
    assign is_rw  = !i_cmd.cs_n && i_cmd.ras_n && !i_cmd.cas_n;
    assign is_pre = !i_cmd.cs_n && !i_cmd.ras_n && i_cmd.cas_n && !i_cmd.we_n;
    assign is_ref = !i_cmd.cs_n && !i_cmd.ras_n && !i_cmd.cas_n && i_cmd.we_n;

    // commands only count while running with cke high on both edges
    assign cmd_live  = (state_q == ST_RUN) && cke_prev_q && i_cmd.cke;
    assign do_act    = cmd_live && is_act;
    assign do_rw     = cmd_live && is_rw;
    assign do_pre    = cmd_live && is_pre;
    assign do_ref    = cmd_live && is_ref;
    assign enter_sr  = (state_q == ST_RUN) && cke_prev_q && !i_cmd.cke && is_ref;
    assign enter_pd  = (state_q == ST_RUN) && cke_prev_q && !i_cmd.cke && is_nop;
    // self-refresh exit needs only cke; power-down exit wants a nop too
    assign leave_low = i_cmd.cke && ((state_q == ST_SELF_REF) || is_nop);

    // ------------------------------------------------------------
    // write recovery setting
    // ------------------------------------------------------------
    logic [2:0] wr_q;
    logic       wr_reject_q;

    // out-of-range values keep the last legal setting
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            wr_q        <= WR_RESET;
            wr_reject_q <= 1'b0;
        end else if (i_mode.wr_cycles >= WR_MIN && i_mode.wr_cycles <= WR_MAX) begin
            wr_q        <= i_mode.wr_cycles;
            wr_reject_q <= 1'b0;
        end else begin
            wr_reject_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // auto-precharge delays
    // ------------------------------------------------------------
    logic [DLY_W-1:0] half_bl;
    logic [DLY_W-1:0] wr_ap_delay;
    logic [DLY_W-1:0] rd_ap_delay;
    logic [DLY_W-1:0] ap_delay;

    assign half_bl     = DLY_W'(i_mode.burst8 ? HALF_BL8 : HALF_BL4);
    // WL = AL + CL - 1, then burst, then programmed recovery
    assign wr_ap_delay = DLY_W'(i_mode.add_lat) + DLY_W'(i_mode.cas_lat) - DLY_W'(1)
                       + half_bl + DLY_W'(wr_q);
    assign rd_ap_delay = DLY_W'(i_mode.add_lat) + half_bl;
    assign ap_delay    = i_cmd.we_n ? rd_ap_delay : wr_ap_delay;

    // ------------------------------------------------------------
    // bank trackers
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_BANKS-1:0] bank_idle;

    // each bank decodes its own address, so others keep working during AP
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic hit;
        assign hit = (i_cmd.ba == BANK_W'(b));
        ddr2_bank_state u_bank (
            .i_sys_clk  (i_sys_clk),
            .i_reset_n  (i_reset_n),
            .i_activate (do_act && hit),
            .i_precharge(do_pre && (hit || i_cmd.addr[AP_BIT])),
            .i_auto_pre (do_rw && hit && i_cmd.addr[AP_BIT]),
            .i_ap_delay (ap_delay),
            .o_open     (bank_open[b]),
            .o_idle     (bank_idle[b])
        );
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (enter_sr) begin
                    state_d = ST_SELF_REF;
                end else if (enter_pd) begin
                    // open row anywhere means active power-down
                    state_d = (|bank_open) ? ST_ACT_PD : ST_PRE_PD;
                end
            end
            ST_SELF_REF, ST_PRE_PD, ST_ACT_PD: begin
                if (leave_low) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    logic slow_exit_q;

    // exit speed latched at entry, steady for the whole stay
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            slow_exit_q <= 1'b0;
        end else if (enter_pd) begin
            slow_exit_q <= i_mode.slow_exit;
        end
    end

    // ------------------------------------------------------------
    // refresh engine
    // ------------------------------------------------------------
    logic [7:0]       rfc_cnt_q;
    logic [11:0]      sr_timer_q;
    logic             sr_tick;
    logic             row_step;
    logic [ROW_W-1:0] row_q;
    logic             strobe_q;

    assign sr_tick  = (state_q == ST_SELF_REF) && (sr_timer_q == 12'h000);
    assign row_step = do_ref || enter_sr || sr_tick;

    // refresh keeps running through a power-down entered meanwhile
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rfc_cnt_q <= 8'h00;
        end else if (row_step) begin
            rfc_cnt_q <= T_RFC_CYC;
        end else if (rfc_cnt_q != 8'h00) begin
            rfc_cnt_q <= rfc_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            sr_timer_q <= T_REFI_CYC;
        end else if (state_q != ST_SELF_REF || sr_tick) begin
            sr_timer_q <= T_REFI_CYC;
        end else begin
            sr_timer_q <= sr_timer_q - 12'h001;
        end
    end

    // external address never reaches the row counter
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            row_q    <= ROW_RESET;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= row_step;
            if (row_step) begin
                row_q <= row_q + ROW_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0] open_out_q;
    logic                 idle_q;
    logic                 busy_q;
    logic                 clk_gated_q;
    logic                 inbuf_q;
    logic                 dll_q;
    logic [ROW_W-1:0]     row_out_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            open_out_q  <= '0;
            idle_q      <= 1'b1;
            busy_q      <= 1'b0;
            clk_gated_q <= 1'b0;
            inbuf_q     <= 1'b1;
            dll_q       <= 1'b1;
            row_out_q   <= ROW_RESET;
        end else begin
            open_out_q  <= bank_open;
            idle_q      <= (&bank_idle) && (rfc_cnt_q == 8'h00);
            busy_q      <= (rfc_cnt_q != 8'h00);
            clk_gated_q <= (state_d == ST_SELF_REF);
            inbuf_q     <= (state_d == ST_RUN);
            // dll stays up only in run and in fast-exit active power-down
            dll_q       <= (state_d == ST_RUN) ||
                           ((state_d == ST_ACT_PD) &&
                            !(enter_pd ? i_mode.slow_exit : slow_exit_q));
            row_out_q   <= row_q;
        end
    end

    assign o_power_state    = state_q;
    assign o_bank_open      = open_out_q;
    assign o_all_idle       = idle_q;
    assign o_refresh_busy   = busy_q;
    assign o_refresh_strobe = strobe_q;
    assign o_refresh_row    = row_out_q;
    assign o_clk_gated      = clk_gated_q;
    assign o_input_buf_en   = inbuf_q;
    assign o_dll_enable     = dll_q;
    assign o_wr_setting     = wr_q;
    assign o_wr_reject      = wr_reject_q;

endmodule : ddr2_cmd_core

/* File: tb/ddr2_ctl_model.sv */
// memory controller model driving the ddr2 command bus
`timescale 1ns/100ps
module ddr2_ctl_model (
    input  wire logic                 i_sys_clk,
    output ddr2_cmd_pkg::cmd_bus_type o_cmd
);
    import ddr2_cmd_pkg::*;
    // ----
    // command issue
    // ----
    initial o_cmd = {1'b0, 4'hF, 3'h0, 14'h0000};

    // op is {ras_n, cas_n, we_n}; the caller picks gap from the spacing it owes
    task automatic send(input logic cke, input logic [2:0] op, input logic [2:0] ba,
                        input logic [13:0] addr, input int gap);
        @(posedge i_sys_clk);
        o_cmd <= {cke, 1'b0, op, ba, addr};
        // nops keep cke where the caller left it
        repeat (gap) begin
            @(posedge i_sys_clk);
            // address is don't care here, so it toggles rather than holding
            o_cmd <= {cke, 4'h7, ~ba, ~o_cmd.addr};
        end
    endtask : send
endmodule : ddr2_ctl_model

/* File: tb/ddr2_cmd_core_properties.sv */
// concurrent checks on the ddr2 command core ports
`timescale 1ns/100ps
module ddr2_cmd_core_properties (
    input wire logic                            i_sys_clk,
    input wire logic                            i_reset_n,
    input wire ddr2_cmd_pkg::cmd_bus_type       i_cmd,
    input wire ddr2_cmd_pkg::mode_type          i_mode,
    input wire ddr2_cmd_pkg::power_state_type   o_power_state,
    input wire logic [7:0]                      o_bank_open,
    input wire logic                            o_all_idle,
    input wire logic                            o_refresh_busy,
    input wire logic                            o_refresh_strobe,
    input wire logic [13:0]                     o_refresh_row,
    input wire logic                            o_clk_gated,
    input wire logic                            o_input_buf_en,
    input wire logic                            o_dll_enable,
    input wire logic [2:0]                      o_wr_setting,
    input wire logic                            o_wr_reject
);
    import ddr2_cmd_pkg::*;
    // ----
    // helpers
    // ----
    logic       cke_q;
    logic       live;
    logic       nop;
    logic       wr_ok;
    logic       run;
    logic [2:0] op;
    logic       slow_q;
    // cke history resets low, as the core's own does
    always_ff @(posedge i_sys_clk) begin
        cke_q <= i_reset_n & i_cmd.cke;
    end
    // exit speed is fixed when power-down is entered
    always_ff @(posedge i_sys_clk) begin
        if (run && cke_q && !i_cmd.cke && nop) begin
            slow_q <= i_mode.slow_exit;
        end
    end
    assign op    = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
    assign run   = o_power_state == ST_RUN;
    assign live  = run && i_cmd.cke && cke_q && !i_cmd.cs_n;
    assign nop   = i_cmd.cs_n || op == 3'h7;
    assign wr_ok = i_mode.wr_cycles >= 3'h2 && i_mode.wr_cycles <= 3'h6;
    // ----
    // properties
    // ----
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    a_ref_strobe: assert property (live && op == 3'h1 |-> ##[1:2] o_refresh_strobe)
        else $error("refresh command gave no row strobe");
    a_row_step: assert property (o_refresh_strobe |=> o_refresh_row == $past(o_refresh_row) + 14'h1)
        else $error("refresh row did not advance by one");
    a_refresh_idle: assert property (o_refresh_busy |-> !o_all_idle)
        else $error("idle reported during refresh cycle");
    a_sr_entry: assert property (run && cke_q && !i_cmd.cke && !i_cmd.cs_n && op == 3'h1
        |-> ##[1:2] o_power_state == ST_SELF_REF) else $error("self refresh not entered");
    a_sr_gate: assert property (o_power_state == ST_SELF_REF
        |-> o_clk_gated && !o_input_buf_en && !o_dll_enable) else $error("self refresh gating wrong");
    a_sr_hold: assert property (o_power_state == ST_SELF_REF && !i_cmd.cke && !$past(i_cmd.cke)
        |=> o_power_state == ST_SELF_REF) else $error("self refresh left with cke low");
    a_pd_entry: assert property (run && cke_q && !i_cmd.cke && nop
        |-> ##[1:2] o_power_state[1]) else $error("power down not entered");
    a_pd_kind: assert property (o_power_state == ST_PRE_PD |-> o_bank_open == 8'h00)
        else $error("precharge power down with open row");
    a_pd_bufs: assert property (o_power_state[1] |-> !o_input_buf_en && !o_clk_gated
        && o_dll_enable == (o_power_state == ST_ACT_PD && !slow_q))
        else $error("power down buffer or dll state wrong");
    a_pd_exit: assert property (o_power_state[1] && i_cmd.cke && nop |-> ##[1:2] run)
        else $error("power down not left");
    a_wr_keep: assert property ((wr_ok && $stable(i_mode.wr_cycles)) [*3]
        |-> o_wr_setting == i_mode.wr_cycles && !o_wr_reject) else $error("write recovery not taken");
    a_wr_refuse: assert property ((!wr_ok && $stable(i_mode.wr_cycles)) [*3]
        |-> o_wr_reject && $stable(o_wr_setting)) else $error("bad write recovery taken");

    c_self_ref: cover property (o_power_state == ST_SELF_REF ##1 o_refresh_strobe);
    c_fast_pd: cover property (o_power_state == ST_ACT_PD && o_dll_enable);
    c_ap_close: cover property ($fell(o_bank_open[0]) && o_bank_open[1]);
endmodule : ddr2_cmd_core_properties

bind ddr2_cmd_core ddr2_cmd_core_properties chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cmd(i_cmd), .i_mode(i_mode),
    .o_power_state(o_power_state), .o_bank_open(o_bank_open), .o_all_idle(o_all_idle),
    .o_refresh_busy(o_refresh_busy), .o_refresh_strobe(o_refresh_strobe),
    .o_refresh_row(o_refresh_row), .o_clk_gated(o_clk_gated), .o_input_buf_en(o_input_buf_en),
    .o_dll_enable(o_dll_enable), .o_wr_setting(o_wr_setting), .o_wr_reject(o_wr_reject)
);

/* File: tb/ddr2_autoprecharge_refresh_powerdown_tb_top.sv */
// self-checking bench for the ddr2 command core
`timescale 1ns/100ps
module ddr2_autoprecharge_refresh_powerdown_tb_top;
    import ddr2_cmd_pkg::*;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_WR  = 3'h4;
    localparam logic [2:0] OP_RD  = 3'h5;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_REF = 3'h1;
    localparam logic [2:0] OP_NOP = 3'h7;
    logic            i_sys_clk;
    logic            i_reset_n;
    mode_type        mode;
    cmd_bus_type     cmd;
    power_state_type pst;
    logic [7:0]      bopen;
    logic [13:0]     row;
    logic [2:0]      wrs;
    logic            idle, busy, strobe, gated, bufen, dll, wrej;
    int              failures;
    int              num_checks;
    // ----
    // structure
    // ----
    ddr2_cmd_core dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cmd(cmd), .i_mode(mode),
        .o_power_state(pst), .o_bank_open(bopen), .o_all_idle(idle), .o_refresh_busy(busy),
        .o_refresh_strobe(strobe), .o_refresh_row(row), .o_clk_gated(gated),
        .o_input_buf_en(bufen), .o_dll_enable(dll), .o_wr_setting(wrs), .o_wr_reject(wrej)
    );
    ddr2_ctl_model ctl (.i_sys_clk(i_sys_clk), .o_cmd(cmd));
    // ----
    // helpers
    // ----
    task automatic tick();
        @(posedge i_sys_clk);
        #1;
    endtask : tick

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // sel 0 waits for a row strobe, sel 1 for the refresh cycle to end
    task automatic wait_on(input int sel, input int max);
        int n;
        n = 0;
        while (!(sel == 1 ? busy === 1'b0 : strobe === 1'b1)) begin
            tick();
            n++;
            if (n > max) begin
                failures++;
                tally_and_finish();
            end
        end
    endtask : wait_on
    // ----
    // scenarios
    // ----
    task automatic t_write_ap();
        ctl.send(1'b1, OP_ACT, 3'h0, 14'h0123, 1);
        ctl.send(1'b1, OP_ACT, 3'h1, 14'h0456, 3);
        ctl.send(1'b1, OP_WR, 3'h0, 14'h0400, 1);
        ctl.send(1'b1, OP_WR, 3'h1, 14'h0008, 2);
        #1;
        check(bopen, 8'h03);
        // precharge lands WL + BL/2 + WR = 7 edges after the write
        repeat (4) tick();
        check(bopen, 8'h03);
        tick();
        check(bopen, 8'h02);
        // bank address ignored: A10 high closes every bank
        ctl.send(1'b1, OP_PRE, 3'h6, 14'h0400, 8);
        #1;
        check({bopen, idle}, 9'h001);
    endtask : t_write_ap

    task automatic t_refresh();
        logic [13:0] r0;
        r0 = row;
        ctl.send(1'b1, OP_REF, 3'h7, 14'h3FFF, 1);
        // strobe settles only after the launching edge
        #1;
        wait_on(0, 4);
        tick();
        check(row, r0 + 14'h1);
        check({busy, idle}, 2'h2);
        wait_on(1, 40);
        tick();
        check({bopen, idle}, 9'h001);
    endtask : t_refresh

    task automatic t_self_ref();
        logic [13:0] r0;
        ctl.send(1'b0, OP_REF, 3'h0, 14'h0000, 4);
        ctl.send(1'b0, OP_ACT, 3'h5, 14'h0777, 2);
        #1;
        r0 = row;
        check({pst, gated, bufen, dll, bopen}, {ST_SELF_REF, 3'h4, 8'h00});
        wait_on(0, 1600);
        tick();
        check(row, r0 + 14'h1);
        ctl.send(1'b1, OP_NOP, 3'h0, 14'h0000, 30);
        #1;
        check({pst, gated, bufen}, {ST_RUN, 2'h1});
    endtask : t_self_ref

    task automatic t_power_down();
        ctl.send(1'b0, OP_NOP, 3'h0, 14'h0000, 3);
        #1;
        check({pst, bufen, dll}, {ST_PRE_PD, 2'h0});
        ctl.send(1'b1, OP_NOP, 3'h0, 14'h0000, 3);
        #1;
        check(pst, ST_RUN);
        ctl.send(1'b1, OP_ACT, 3'h2, 14'h0042, 12);
        for (int s = 0; s < 2; s++) begin
            @(posedge i_sys_clk) mode.slow_exit <= s[0];
            ctl.send(1'b0, OP_NOP, 3'h0, 14'h0000, 3);
            #1;
            check({pst, bufen, dll}, {ST_ACT_PD, 1'b0, ~s[0]});
            ctl.send(1'b1, OP_NOP, 3'h0, 14'h0000, 3);
            #1;
            check({pst, bopen}, {ST_RUN, 8'h04});
        end
        @(posedge i_sys_clk) mode.burst8 <= 1'b1;
        // read with AP closes AL + BL/2 = 4 edges after the read
        ctl.send(1'b1, OP_RD, 3'h2, 14'h0400, 3);
        #1;
        check(bopen, 8'h04);
        repeat (2) tick();
        check(bopen, 8'h04);
        tick();
        check(bopen, 8'h00);
    endtask : t_power_down

    task automatic t_wr_range();
        logic [2:0] keep;
        keep = 3'h3;
        for (int w = 0; w < 8; w++) begin
            @(posedge i_sys_clk) mode.wr_cycles <= w[2:0];
            repeat (4) tick();
            if (w >= 2 && w <= 6) keep = w[2:0];
            check({wrej, wrs}, {!(w >= 2 && w <= 6), keep});
        end
        @(posedge i_sys_clk) mode.wr_cycles <= 3'h3;
    endtask : t_wr_range
    // ----
    // main sequence
    // ----
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        failures = 0;
        num_checks = 0;
        i_reset_n = 1'b0;
        mode = '{cas_lat: 3'h3, add_lat: 3'h0, burst8: 1'b0, wr_cycles: 3'h3, slow_exit: 1'b0};
        repeat (11) @(posedge i_sys_clk);
        #1;
        check({pst, bopen, idle, busy, strobe, gated, bufen, dll, wrs, wrej, row},
              {ST_RUN, 8'h00, 6'h23, 3'h2, 1'b0, 14'h0000});
        @(posedge i_sys_clk) i_reset_n <= 1'b1;
        ctl.send(1'b1, OP_NOP, 3'h0, 14'h0000, 3);
        t_write_ap();
        t_refresh();
        t_self_ref();
        t_power_down();
        t_wr_range();
        tally_and_finish();
    end
endmodule : ddr2_autoprecharge_refresh_powerdown_tb_top
